// ---- design/ascr_regbank.sv ----
/*
 file holds the serial-programmed configuration register bank top.
 assumes serial clock at most a sixth of i_sys_clk so every edge is seen.
*/
// What this block does
// - clock divider register resets to 80h, fixed bits
// - divider code selects ratio 1, 2, 1, 4
// - sync delay register resets 00h, upper bits zero
// - three-bit sync delay code, 60 ps steps
// - power and format register resets to zero
// - sixteen-bit word committed on sixteenth rising edge
// - read flag set blocks writes until cleared
// - software reset bit restores defaults, self-clears
`timescale 1ns/1ps
`include "ascr_params.svh"
module ascr_regbank
	import ascr_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_serial_select_n,
	input wire logic i_serial_clk,
	input wire logic i_serial_data_in,
	output logic o_serial_data_out,
	output logic o_serial_data_out_oe,
	output ascr_ctrl_t o_ctrl,
	output logic [2:0] o_div_ratio,
	output logic [8:0] o_sync_delay_ps,
	output logic [7:0] o_gain_a,
	output logic [7:0] o_gain_b,
	output logic [7:0] o_fovr_pin,
	output logic [7:0] o_hfm_b,
	output logic [7:0] o_test_pat,
	output logic [15:0] o_custom_pat1,
	output logic [15:0] o_custom_pat2,
	output logic [7:0] o_drive,
	output logic [7:0] o_ddr_timing,
	output logic [7:0] o_qdr_timing_a,
	output logic [7:0] o_qdr_timing_b,
	output logic [7:0] o_fovr_threshold
);
	logic sel_n;
	logic sclk;
	logic sdin;
	logic sclk_rise;
	logic sclk_fall;
	logic sclk_d_r;
	logic sclk_d_r_q;
	ascr_state_t state_r;
	logic [4:0] bit_cnt_r;
	logic [15:0] shift_r;
	ascr_word_t word;
	logic commit;
	logic readback_r;
	logic swrst;
	logic [7:0] rd_data;
	logic mapped;
	logic [7:0] rd_shift_r;
	logic [7:0] clkdiv_r;
	logic [7:0] syncdly_r;
	logic [7:0] pwrfmt_r;
	logic [7:0] gain_a_r;
	logic [7:0] gain_b_r;
	logic [7:0] fovr_pin_r;
	logic [7:0] hfm_b_r;
	logic [7:0] test_pat_r;
	logic [7:0] cp1_hi_r;
	logic [7:0] cp1_lo_r;
	logic [7:0] cp2_hi_r;
	logic [7:0] cp2_lo_r;
	logic [7:0] drive_r;
	logic [7:0] rate_r;
	logic [7:0] ddr_tim_r;
	logic [7:0] qdr_a_r;
	logic [7:0] qdr_b_r;
	logic [7:0] fovr_th_r;
	logic [7:0] ctrlpin_r;
	logic wr_ok;

	ascr_sync #(.RST_VAL(1'b1)) u_sync_sel (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_pin(i_serial_select_n),
		.o_level(sel_n),
		.o_rise()
	);
	ascr_sync #(.RST_VAL(1'b0)) u_sync_sclk (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_pin(i_serial_clk),
		.o_level(sclk),
		.o_rise()
	);
	ascr_sync #(.RST_VAL(1'b0)) u_sync_sdin (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_pin(i_serial_data_in),
		.o_level(sdin),
		.o_rise()
	);

	// edges taken from the filtered level keep data aligned with its clock
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk;
		end
	end
	assign sclk_rise = sclk & ~sclk_d_r & ~sel_n;
	assign sclk_fall = ~sclk & sclk_d_r & ~sel_n;

	// excess bits past a multiple of sixteen simply never commit
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_r <= ASCR_IDLE;
			bit_cnt_r <= 5'h00;
			shift_r <= 16'h0000;
		end else if (sel_n) begin
			state_r <= ASCR_IDLE;
			bit_cnt_r <= 5'h00;
		end else begin
			case (state_r)
			ASCR_IDLE, ASCR_DONE: begin
				if (sclk_rise) begin
					state_r <= ASCR_SHIFT;
					bit_cnt_r <= 5'h01;
					shift_r <= {shift_r[14:0], sdin};
				end else begin
					state_r <= ASCR_IDLE;
				end
			end
			ASCR_SHIFT: begin
				if (sclk_rise) begin
					shift_r <= {shift_r[14:0], sdin};
					if (bit_cnt_r == `ASCR_LAST_BIT) begin
						state_r <= ASCR_DONE;
						bit_cnt_r <= 5'h00;
					end else begin
						bit_cnt_r <= bit_cnt_r + 5'h01;
					end
				end
			end
			default: begin
				state_r <= ASCR_IDLE;
				bit_cnt_r <= 5'h00;
			end
			endcase
		end
	end

	assign commit = (state_r == ASCR_DONE) && (bit_cnt_r == 5'h00) &&
		!sclk_d_r_q;
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sclk_d_r_q <= 1'b0;
		end else begin
			sclk_d_r_q <= (state_r == ASCR_DONE);
		end
	end
	assign word = shift_r;

	// readback flag is the word's own top bit, latched at each commit
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			readback_r <= 1'b0;
		end else if (commit) begin
			readback_r <= word.rd_flag;
		end
	end
	// a word that clears the flag is itself a write
	assign wr_ok = commit && !word.rd_flag;

	always_comb begin
		mapped = 1'b1;
		rd_data = 8'h00;
		case (word.addr)
		`ASCR_ADDR_CLKDIV: rd_data = clkdiv_r;
		`ASCR_ADDR_SYNCDLY: rd_data = syncdly_r;
		`ASCR_ADDR_PWRFMT: rd_data = pwrfmt_r;
		`ASCR_ADDR_GAIN_A: rd_data = gain_a_r;
		`ASCR_ADDR_GAIN_B: rd_data = gain_b_r;
		`ASCR_ADDR_FOVR_PIN: rd_data = fovr_pin_r;
		`ASCR_ADDR_HFM_B: rd_data = hfm_b_r;
		`ASCR_ADDR_TESTPAT: rd_data = test_pat_r;
		`ASCR_ADDR_CP1_HI: rd_data = cp1_hi_r;
		`ASCR_ADDR_CP1_LO: rd_data = cp1_lo_r;
		`ASCR_ADDR_CP2_HI: rd_data = cp2_hi_r;
		`ASCR_ADDR_CP2_LO: rd_data = cp2_lo_r;
		`ASCR_ADDR_DRIVE: rd_data = drive_r;
		`ASCR_ADDR_RATE: rd_data = rate_r;
		`ASCR_ADDR_DDR_TIM: rd_data = ddr_tim_r;
		`ASCR_ADDR_QDR_A: rd_data = qdr_a_r;
		`ASCR_ADDR_QDR_B: rd_data = qdr_b_r;
		`ASCR_ADDR_FOVR_TH: rd_data = fovr_th_r;
		`ASCR_ADDR_CTRLPIN: rd_data = ctrlpin_r;
		default: mapped = 1'b0;
		endcase
	end

	assign swrst = wr_ok && (word.addr == `ASCR_ADDR_PWRFMT) &&
		word.data[`ASCR_BIT_SWRST];

	// software reset wins over the write that carries it, so the bit
	// reads back zero at once
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			clkdiv_r <= `ASCR_RST_CLKDIV;
			syncdly_r <= `ASCR_RST_ZERO;
			pwrfmt_r <= `ASCR_RST_ZERO;
		end else if (swrst) begin
			clkdiv_r <= `ASCR_RST_CLKDIV;
			syncdly_r <= `ASCR_RST_ZERO;
			pwrfmt_r <= `ASCR_RST_ZERO;
		end else if (wr_ok && mapped) begin
			case (word.addr)
			`ASCR_ADDR_CLKDIV: begin
				clkdiv_r <= `ASCR_FIXED_CLKDIV |
					(word.data & `ASCR_MASK_CLKDIV);
			end
			`ASCR_ADDR_SYNCDLY: begin
				syncdly_r <= word.data & `ASCR_MASK_SYNCDLY;
			end
			`ASCR_ADDR_PWRFMT: begin
				pwrfmt_r <= word.data & 8'hFC;
			end
			default: begin
			end
			endcase
		end
	end

	// remaining registers; 0Dh and 0Eh accept 90h for high frequency
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{gain_a_r, gain_b_r, fovr_pin_r, hfm_b_r} <= 32'h00000000;
			{test_pat_r, cp1_hi_r, cp1_lo_r, cp2_hi_r} <= 32'h00000000;
			{cp2_lo_r, drive_r, rate_r, ddr_tim_r} <= 32'h00000000;
			{qdr_a_r, qdr_b_r, fovr_th_r, ctrlpin_r} <= 32'h00000000;
		end else if (swrst) begin
			{gain_a_r, gain_b_r, fovr_pin_r, hfm_b_r} <= 32'h00000000;
			{test_pat_r, cp1_hi_r, cp1_lo_r, cp2_hi_r} <= 32'h00000000;
			{cp2_lo_r, drive_r, rate_r, ddr_tim_r} <= 32'h00000000;
			{qdr_a_r, qdr_b_r, fovr_th_r, ctrlpin_r} <= 32'h00000000;
		end else if (wr_ok) begin
			case (word.addr)
			`ASCR_ADDR_GAIN_A: gain_a_r <= word.data & 8'hFD;
			`ASCR_ADDR_GAIN_B: gain_b_r <= word.data;
			`ASCR_ADDR_FOVR_PIN: fovr_pin_r <= word.data;
			`ASCR_ADDR_HFM_B: hfm_b_r <= word.data;
			`ASCR_ADDR_TESTPAT: test_pat_r <= word.data;
			`ASCR_ADDR_CP1_HI: cp1_hi_r <= word.data;
			`ASCR_ADDR_CP1_LO: cp1_lo_r <= word.data;
			`ASCR_ADDR_CP2_HI: cp2_hi_r <= word.data;
			`ASCR_ADDR_CP2_LO: cp2_lo_r <= word.data;
			`ASCR_ADDR_DRIVE: drive_r <= word.data & 8'h0F;
			`ASCR_ADDR_RATE: rate_r <= word.data & 8'h01;
			`ASCR_ADDR_DDR_TIM: ddr_tim_r <= word.data & 8'h3E;
			`ASCR_ADDR_QDR_A: qdr_a_r <= word.data & 8'hBF;
			`ASCR_ADDR_QDR_B: qdr_b_r <= word.data & 8'h3F;
			`ASCR_ADDR_FOVR_TH: fovr_th_r <= word.data & 8'h7F;
			`ASCR_ADDR_CTRLPIN: ctrlpin_r <= word.data & 8'h01;
			default: begin
			end
			endcase
		end
	end

	// readout: data of the addressed register leaves during the next word,
	// changed on falling edges so the host samples it on the rising edge
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_shift_r <= 8'h00;
			o_serial_data_out <= 1'b0;
		end else if (commit && word.rd_flag) begin
			rd_shift_r <= rd_data;
		end else if (readback_r && sclk_fall &&
				bit_cnt_r >= `ASCR_DATA_BIT_FIRST) begin
			o_serial_data_out <= rd_shift_r[7];
			rd_shift_r <= {rd_shift_r[6:0], 1'b0};
		end
	end
	assign o_serial_data_out_oe = readback_r & ~sel_n;

	always_comb begin
		o_ctrl.clk_div_sel = clkdiv_r[1:0];
		o_ctrl.sync_input_delay_sel = syncdly_r[2:0];
		o_ctrl.channel_a_powerdown = pwrfmt_r[7];
		o_ctrl.channel_b_powerdown = pwrfmt_r[6];
		o_ctrl.standby_select = pwrfmt_r[5];
		o_ctrl.data_format = pwrfmt_r[4];
		o_ctrl.control_pin_override = pwrfmt_r[3];
		o_ctrl.test_pat_align = pwrfmt_r[2];
		o_ctrl.control_pin_function_sel = ctrlpin_r[0];
		o_ctrl.ddr_qdr_sel = rate_r[0];
	end

	always_comb begin
		case (clkdiv_r[1:0])
		`ASCR_DIV1_A: o_div_ratio = 3'h1;
		`ASCR_DIV2: o_div_ratio = 3'h2;
		`ASCR_DIV1_B: o_div_ratio = 3'h1;
		`ASCR_DIV4: o_div_ratio = 3'h4;
		default: o_div_ratio = 3'h1;
		endcase
	end
	// delay itself is analog; nominal picoseconds reported for reference
	// widen before the product so code 7 does not wrap at six bits
	assign o_sync_delay_ps = 9'(syncdly_r[2:0]) * 9'd60;

	assign o_gain_a = gain_a_r;
	assign o_gain_b = gain_b_r;
	assign o_fovr_pin = fovr_pin_r;
	assign o_hfm_b = hfm_b_r;
	assign o_test_pat = test_pat_r;
	assign o_custom_pat1 = {cp1_hi_r, cp1_lo_r};
	assign o_custom_pat2 = {cp2_hi_r, cp2_lo_r};
	assign o_drive = drive_r;
	assign o_ddr_timing = ddr_tim_r;
	assign o_qdr_timing_a = qdr_a_r;
	assign o_qdr_timing_b = qdr_b_r;
	assign o_fovr_threshold = fovr_th_r;

	property p_clkdiv_fixed;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		clkdiv_r[7:2] == 6'h20;
	endproperty
	a_clkdiv_fixed: assert property (p_clkdiv_fixed)
		else $error("clock divider fixed bits wrong");

	property p_div_ratio;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		clkdiv_r[1:0] == 2'h3 |-> o_div_ratio == 3'h4;
	endproperty
	a_div_ratio: assert property (p_div_ratio)
		else $error("divide by four not selected");

	property p_syncdly_upper;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		syncdly_r[7:3] == 5'h00;
	endproperty
	a_syncdly_upper: assert property (p_syncdly_upper)
		else $error("sync delay upper bits set");

	property p_delay_ps;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		syncdly_r[2:0] == 3'h7 |-> o_sync_delay_ps == 9'd420;
	endproperty
	a_delay_ps: assert property (p_delay_ps)
		else $error("sync delay figure wrong");

	property p_swrst;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		swrst |=> (pwrfmt_r == 8'h00 && clkdiv_r == 8'h80 &&
			hfm_b_r == 8'h00);
	endproperty
	a_swrst: assert property (p_swrst)
		else $error("software reset did not restore defaults");

	property p_hfm_write;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		wr_ok && word.addr == 6'h0E |=> hfm_b_r == $past(word.data);
	endproperty
	a_hfm_write: assert property (p_hfm_write)
		else $error("high frequency register not written");

	property p_read_blocks;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		commit && word.rd_flag |=> $stable(pwrfmt_r) && $stable(gain_a_r);
	endproperty
	a_read_blocks: assert property (p_read_blocks)
		else $error("write taken in readback mode");

	property p_unmapped;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		commit && !mapped |=> $stable(clkdiv_r) && $stable(ctrlpin_r);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped write changed state");

	property p_commit_count;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		commit |-> $past(state_r) == ASCR_SHIFT &&
			$past(bit_cnt_r) == `ASCR_LAST_BIT;
	endproperty
	a_commit_count: assert property (p_commit_count)
		else $error("commit without sixteen bits");

	c_write: cover property (@(posedge i_sys_clk) wr_ok && mapped);
	c_read: cover property (@(posedge i_sys_clk) commit && word.rd_flag);
	c_swrst: cover property (@(posedge i_sys_clk) swrst);
endmodule : ascr_regbank

// ---- design/ascr_params.svh ----
/*
 file holds offsets, field positions, reset values and timing counts of the
 serial configuration register bank. assumes inclusion by bare name.
*/
`ifndef ASCR_PARAMS_SVH
`define ASCR_PARAMS_SVH
`define ASCR_ADDR_CLKDIV 6'h06
`define ASCR_ADDR_SYNCDLY 6'h07
`define ASCR_ADDR_PWRFMT 6'h08
`define ASCR_ADDR_GAIN_A 6'h0B
`define ASCR_ADDR_GAIN_B 6'h0C
`define ASCR_ADDR_FOVR_PIN 6'h0D
`define ASCR_ADDR_HFM_B 6'h0E
`define ASCR_ADDR_TESTPAT 6'h0F
`define ASCR_ADDR_CP1_HI 6'h10
`define ASCR_ADDR_CP1_LO 6'h11
`define ASCR_ADDR_CP2_HI 6'h12
`define ASCR_ADDR_CP2_LO 6'h13
`define ASCR_ADDR_DRIVE 6'h14
`define ASCR_ADDR_RATE 6'h15
`define ASCR_ADDR_DDR_TIM 6'h16
`define ASCR_ADDR_QDR_A 6'h17
`define ASCR_ADDR_QDR_B 6'h18
`define ASCR_ADDR_FOVR_TH 6'h1F
`define ASCR_ADDR_CTRLPIN 6'h20
`define ASCR_RST_CLKDIV 8'h80
`define ASCR_RST_ZERO 8'h00
`define ASCR_RST_FOVR_PIN 8'h00
`define ASCR_FIXED_CLKDIV 8'h80
`define ASCR_MASK_CLKDIV 8'h03
`define ASCR_MASK_SYNCDLY 8'h07
`define ASCR_BIT_SWRST 0
`define ASCR_WORD_BITS 5'h10
`define ASCR_LAST_BIT 5'h0F
`define ASCR_DATA_BIT_FIRST 5'h08
`define ASCR_DIV1_A 2'h0
`define ASCR_DIV2 2'h1
`define ASCR_DIV1_B 2'h2
`define ASCR_DIV4 2'h3
`endif

// ---- design/ascr_pkg.sv ----
/*
 package holds the types of the serial configuration register bank.
 assumes the params header is included before use of the widths.
*/
package ascr_pkg;
	typedef struct packed {
		logic rd_flag;
		logic zero_bit;
		logic [5:0] addr;
		logic [7:0] data;
	} ascr_word_t;

	typedef struct packed {
		logic [1:0] clk_div_sel;
		logic [2:0] sync_input_delay_sel;
		logic channel_a_powerdown;
		logic channel_b_powerdown;
		logic standby_select;
		logic data_format;
		logic control_pin_override;
		logic test_pat_align;
		logic control_pin_function_sel;
		logic ddr_qdr_sel;
	} ascr_ctrl_t;

	typedef enum logic [2:0] {
		ASCR_IDLE = 3'b001,
		ASCR_SHIFT = 3'b010,
		ASCR_DONE = 3'b100
	} ascr_state_t;
endpackage : ascr_pkg

// ---- design/ascr_sync.sv ----
/*
 file holds a three-stage pin synchroniser with agreement filter.
 assumes the input is asynchronous to i_sys_clk.
*/
`timescale 1ns/1ps
module ascr_sync
	import ascr_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_pin,
	output logic o_level,
	output logic o_rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic lvl_r;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else begin
			s1_r <= i_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lvl_r <= RST_VAL;
		end else if (s2_r == s3_r) begin
			lvl_r <= s3_r;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_level <= RST_VAL;
			o_rise <= 1'b0;
		end else begin
			o_level <= lvl_r;
			o_rise <= lvl_r & ~o_level;
		end
	end
endmodule : ascr_sync

// ---- testbench/ascr_host_model.sv ----
/*
 serial controller model standing on the far side of the register bank.
 assumes the bench calls its tasks and that they run on falling sys edges.
*/
`timescale 1ns/1ps
module ascr_host_model (
	input wire logic i_sys_clk,
	input wire logic i_serial_data_out,
	input wire logic i_serial_data_out_oe,
	output logic o_serial_select_n,
	output logic o_serial_clk,
	output logic o_serial_data_in
);
	logic [7:0] rd_byte;
	logic rd_oe;

	initial begin
		o_serial_select_n = 1'b1;
		o_serial_clk = 1'b0;
		o_serial_data_in = 1'b0;
		rd_byte = 8'h00;
		rd_oe = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : wait_clk

	// half period of 8 sys clocks: the pin filter needs at least 2
	task automatic put_bit(input logic b, input logic cap);
		o_serial_data_in = b;
		wait_clk(8);
		if (cap) begin
			rd_byte = {rd_byte[6:0], i_serial_data_out};
			rd_oe = rd_oe & i_serial_data_out_oe;
		end
		o_serial_clk = 1'b1;
		wait_clk(8);
		o_serial_clk = 1'b0;
	endtask : put_bit

	// flag, zero bit, address, data, msb first
	task automatic put_word(input logic [15:0] w, input logic cap);
		if (cap)
			rd_oe = 1'b1;
		for (int i = 15; i >= 0; i--) begin
			put_bit(w[i], cap && i < 8);
		end
	endtask : put_word

	task automatic select(input logic on);
		if (on) begin
			wait_clk(1);
			o_serial_select_n = 1'b0;
			wait_clk(8);
		end else begin
			wait_clk(8);
			o_serial_select_n = 1'b1;
			// released line: never leave the last bit showing
			o_serial_data_in = ~o_serial_data_in;
			wait_clk(16);
		end
	endtask : select
endmodule : ascr_host_model

// ---- testbench/tb.sv ----
/*
 self-checking bench of the serial configuration register bank.
 assumes the host model drives the serial pins and 40 MHz sys clock.
*/
`timescale 1ns/1ps
`include "ascr_params.svh"
module tb
	import ascr_pkg::*;
;
	logic i_sys_clk;
	logic i_rst_b;
	logic sel_n, sclk, sdi, sdo, sdo_oe;
	ascr_ctrl_t ctrl;
	logic [2:0] div_ratio;
	logic [8:0] dly_ps;
	logic [7:0] gain_a, gain_b, fovr_pin, hfm_b;
	logic [15:0] pat1, pat2;
	logic [7:0] test_pat, drive, ddr_tim, qdr_a, qdr_b, fovr_th;
	logic [2:0] ratio_tab [4] = '{3'h1, 3'h2, 3'h1, 3'h4};
	int fails;
	int check_count;

	ascr_regbank uut (
		.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_serial_select_n(sel_n), .i_serial_clk(sclk),
		.i_serial_data_in(sdi), .o_serial_data_out(sdo),
		.o_serial_data_out_oe(sdo_oe), .o_ctrl(ctrl),
		.o_div_ratio(div_ratio), .o_sync_delay_ps(dly_ps),
		.o_gain_a(gain_a), .o_gain_b(gain_b), .o_fovr_pin(fovr_pin),
		.o_hfm_b(hfm_b), .o_test_pat(test_pat), .o_custom_pat1(pat1),
		.o_custom_pat2(pat2), .o_drive(drive), .o_ddr_timing(ddr_tim),
		.o_qdr_timing_a(qdr_a), .o_qdr_timing_b(qdr_b),
		.o_fovr_threshold(fovr_th)
	);

	ascr_host_model host (
		.i_sys_clk(i_sys_clk), .i_serial_data_out(sdo),
		.i_serial_data_out_oe(sdo_oe), .o_serial_select_n(sel_n),
		.o_serial_clk(sclk), .o_serial_data_in(sdi)
	);

	initial begin
		i_sys_clk = 1'b0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end

	task automatic chk(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host.select(1'b1);
		host.put_word({2'b00, a, d}, 1'b0);
		host.select(1'b0);
	endtask : wr

	// read word, then a capture word, then a flag-clear word to 3Fh
	task automatic rdchk(input string nm, input logic [5:0] a,
			input logic [7:0] e);
		host.select(1'b1);
		host.put_word({2'b10, a, 8'h00}, 1'b0);
		host.put_word({2'b10, 6'h3F, 8'h00}, 1'b1);
		host.put_word({2'b00, 6'h3F, 8'h00}, 1'b0);
		host.select(1'b0);
		chk(nm, {8'h00, e}, {8'h00, host.rd_byte});
		chk("readback enable", 16'h0001, {15'h0000, host.rd_oe});
		chk("readback off", 16'h0000, {15'h0000, sdo_oe});
	endtask : rdchk

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	initial begin
		repeat (40000) @(posedge i_sys_clk);
		fails++;
		$display("BAD watchdog expected done seen timeout");
		finish_test();
	end

	initial begin
		fails = 0;
		check_count = 0;
		i_rst_b = 1'b0;
		repeat (3) @(negedge i_sys_clk);
		i_rst_b = 1'b1;
		repeat (10) @(negedge i_sys_clk);
		rdchk("clkdiv reset", `ASCR_ADDR_CLKDIV, 8'h80);
		rdchk("syncdly reset", `ASCR_ADDR_SYNCDLY, 8'h00);
		rdchk("pwrfmt reset", `ASCR_ADDR_PWRFMT, 8'h00);
		chk("ratio reset", 16'h0001, {13'h0000, div_ratio});
		for (int c = 0; c < 4; c++) begin
			wr(`ASCR_ADDR_CLKDIV, 8'h80 | 8'(c));
			chk("ratio", {13'h0000, ratio_tab[c]}, {13'h0000, div_ratio});
			chk("div field", 16'(c), {14'h0000, ctrl.clk_div_sel});
		end
		// host keeps the fixed bits as the map demands
		wr(`ASCR_ADDR_CLKDIV, 8'h82);
		rdchk("clkdiv fixed", `ASCR_ADDR_CLKDIV, 8'h82);
		for (int c = 0; c < 8; c++) begin
			wr(`ASCR_ADDR_SYNCDLY, 8'(c));
			chk("delay ps", 16'(c * 60), {7'h00, dly_ps});
			chk("delay field", 16'(c), {13'h0000, ctrl.sync_input_delay_sel});
		end
		rdchk("syncdly upper", `ASCR_ADDR_SYNCDLY, 8'h07);
		wr(`ASCR_ADDR_PWRFMT, 8'hF4);
		chk("power fields", 16'h003D, {10'h000, ctrl.channel_a_powerdown,
			ctrl.channel_b_powerdown, ctrl.standby_select, ctrl.data_format,
			ctrl.control_pin_override, ctrl.test_pat_align});
		rdchk("pwrfmt value", `ASCR_ADDR_PWRFMT, 8'hF4);
		wr(`ASCR_ADDR_FOVR_PIN, 8'h90);
		wr(`ASCR_ADDR_HFM_B, 8'h90);
		chk("hf mode a", 16'h0090, {8'h00, fovr_pin});
		chk("hf mode b", 16'h0090, {8'h00, hfm_b});
		// two words in one select, then five excess bits
		host.select(1'b1);
		host.put_word({2'b00, `ASCR_ADDR_CP1_HI, 8'h12}, 1'b0);
		host.put_word({2'b00, `ASCR_ADDR_CP1_LO, 8'h34}, 1'b0);
		for (int i = 0; i < 5; i++)
			host.put_bit(1'b0, 1'b0);
		host.select(1'b0);
		chk("back to back", 16'h1234, pat1);
		// select rises after ten bits: partial word dropped
		host.select(1'b1);
		for (int i = 15; i > 5; i--)
			host.put_bit(logic'(16'h10FF >> i), 1'b0);
		host.select(1'b0);
		chk("aborted word", 16'h1234, pat1);
		wr(`ASCR_ADDR_GAIN_B, 8'h3C);
		host.select(1'b1);
		host.put_word({2'b10, `ASCR_ADDR_GAIN_B, 8'h00}, 1'b0);
		host.put_word({2'b10, `ASCR_ADDR_GAIN_B, 8'hAA}, 1'b0);
		host.select(1'b0);
		chk("blocked write", 16'h003C, {8'h00, gain_b});
		wr(`ASCR_ADDR_GAIN_B, 8'h5A);
		chk("resumed write", 16'h005A, {8'h00, gain_b});
		wr(6'h09, 8'hFF);
		wr(6'h3E, 8'hFF);
		chk("unmapped gain", 16'h005A, {8'h00, gain_b});
		chk("unmapped pat", 16'h1234, pat1);
		rdchk("unmapped clkdiv", `ASCR_ADDR_CLKDIV, 8'h82);
		wr(`ASCR_ADDR_GAIN_A, 8'hA5);
		chk("gain a", 16'h00A5, {8'h00, gain_a});
		wr(`ASCR_ADDR_TESTPAT, 8'hC3);
		wr(`ASCR_ADDR_CP2_HI, 8'hBE);
		wr(`ASCR_ADDR_CP2_LO, 8'hEF);
		wr(`ASCR_ADDR_DRIVE, 8'h0A);
		wr(`ASCR_ADDR_RATE, 8'h01);
		wr(`ASCR_ADDR_DDR_TIM, 8'h2A);
		wr(`ASCR_ADDR_QDR_A, 8'h95);
		wr(`ASCR_ADDR_QDR_B, 8'h25);
		wr(`ASCR_ADDR_FOVR_TH, 8'h5A);
		wr(`ASCR_ADDR_CTRLPIN, 8'h01);
		chk("test pat", 16'h00C3, {8'h00, test_pat});
		chk("pat two", 16'hBEEF, pat2);
		chk("drive", 16'h000A, {8'h00, drive});
		chk("ddr timing", 16'h002A, {8'h00, ddr_tim});
		chk("qdr a", 16'h0095, {8'h00, qdr_a});
		chk("qdr b", 16'h0025, {8'h00, qdr_b});
		chk("fovr th", 16'h005A, {8'h00, fovr_th});
		chk("rate and pins", 16'h0003, {14'h0000, ctrl.ddr_qdr_sel,
			ctrl.control_pin_function_sel});
		wr(`ASCR_ADDR_PWRFMT, 8'h01);
		chk("swrst gain a", 16'h0000, {8'h00, gain_a});
		chk("swrst hf b", 16'h0000, {8'h00, hfm_b});
		chk("swrst pat", 16'h0000, pat1);
		chk("swrst pat two", 16'h0000, pat2);
		chk("swrst test pat", 16'h0000, {8'h00, test_pat});
		chk("swrst drive", 16'h0000, {8'h00, drive});
		chk("swrst ddr", 16'h0000, {8'h00, ddr_tim});
		chk("swrst qdr", 16'h0000, {qdr_a, qdr_b});
		chk("swrst fovr th", 16'h0000, {8'h00, fovr_th});
		chk("swrst pins", 16'h0000, {14'h0000, ctrl.ddr_qdr_sel,
			ctrl.control_pin_function_sel});
		chk("swrst ratio", 16'h0001, {13'h0000, div_ratio});
		rdchk("swrst selfclear", `ASCR_ADDR_PWRFMT, 8'h00);
		rdchk("swrst clkdiv", `ASCR_ADDR_CLKDIV, 8'h80);
		finish_test();
	end
endmodule : tb
